// *** hdl/active_data_pointer_pkg.sv ***
// Constants and carrier types for the dual data pointer block.
// Assumes a single core clock and a core that issues one pointer command per cycle.
package active_data_pointer_pkg;

  // ****************************************************************
  // Widths and special-function addresses
  // ****************************************************************
  localparam int PTR_WIDTH = 16;
  localparam int PTR_COUNT = 2;
  localparam logic [7:0] SFR_AUX_ADDR = 8'hA2;
  localparam logic [7:0] SFR_PTR_LO_ADDR = 8'h82;
  localparam logic [7:0] SFR_PTR_HI_ADDR = 8'h83;
  localparam logic [7:0] SFR_UNMAPPED_DATA = 8'h00;

  // ****************************************************************
  // Auxiliary control layout and reset values
  // ****************************************************************
  localparam int AUX_SEL_BIT = 0;
  localparam int AUX_ZERO_BIT = 2;
  localparam int AUX_WAKE_BIT = 3;
  localparam int AUX_LOWPWR_BIT = 4;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] AUX_WRITE_MASK = 8'hFB;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // ****************************************************************
  // Commands and carriers
  // ****************************************************************
  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_PTR_INC = 3'b001,
    CMD_PTR_LOAD = 3'b010,
    CMD_CODE_READ = 3'b011,
    CMD_EXT_READ = 3'b100,
    CMD_EXT_WRITE = 3'b101,
    CMD_JUMP = 3'b110,
    CMD_AUX_INC = 3'b111
  } cmd_t;

  typedef struct packed {
    cmd_t cmd;
    logic [15:0] imm;
    logic [7:0] accumulator;
  } core_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic code_rd;
    logic ext_rd;
    logic ext_wr;
    logic jump;
  } mem_req_t;

endpackage : active_data_pointer_pkg

// *** hdl/data_pointer_bank.sv ***
// Bank of data pointers; outside reset only the selected entry is changed.
// The bank resolves command priority itself: load, then increment, then low byte, then high byte.
`timescale 1ns/1ps
`default_nettype none
module data_pointer_bank
  import active_data_pointer_pkg::*;
#(
  parameter int WIDTH = PTR_WIDTH,
  parameter int COUNT = PTR_COUNT
)(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Control
  input wire logic [$clog2(COUNT)-1:0] i_sel,
  input wire logic i_inc,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_imm,
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_byte,
  // Pointer values
  output logic [COUNT-1:0][WIDTH-1:0] o_ptr
);

  genvar g;
  generate
    for (g = 0; g < COUNT; g++)
    begin : g_ptr
      logic [WIDTH-1:0] ptr_ff;
      always_ff @(posedge i_ref_clk)
      begin
        if (i_rst)
        begin
          ptr_ff <= PTR_RESET;
        end
        else if (i_sel == g)
        begin
          if (i_load)
          begin
            ptr_ff <= i_imm;
          end
          else if (i_inc)
          begin
            ptr_ff <= ptr_ff + PTR_STEP;
          end
          else if (i_wr_lo)
          begin
            ptr_ff <= {ptr_ff[WIDTH-1:8], i_byte};
          end
          else if (i_wr_hi)
          begin
            ptr_ff <= {i_byte, ptr_ff[7:0]};
          end
        end
      end
      assign o_ptr[g] = ptr_ff;
    end
  endgenerate

endmodule : data_pointer_bank
`default_nettype wire

// *** hdl/dual_data_pointer_select.sv ***
// Dual data pointer with select bit in the auxiliary control register.
// Assumes the core drives requests synchronously on i_ref_clk, one per cycle.
//
// How it works
// [RULE1] Two independent 16-bit pointers address external memory.
// [RULE2] Aux bit 0 picks pointer 0 or 1.
// [RULE3] Aux at A2H; bits 3,2,0 reset to zero.
// [RULE4] Aux bit 2 ignores writes, reads zero.
// [RULE5] Aux increment toggles select, keeps flags.
// [RULE6] Pointer commands act on the selected pointer.
// [RULE7] Pointer increment adds one over 16 bits.
// [RULE8] Immediate load writes 16-bit constant to pointer.
// [RULE9] Code read addresses pointer plus accumulator.
// [RULE10] External read addresses memory at the pointer.
// [RULE11] External write stores accumulator at the pointer.
// [RULE12] Indirect jump targets pointer plus accumulator.
// [RULE13] Pointer low and high bytes reachable separately.
// [RULE14] Software saves select before switching pointers.
// [RULE15] Byte access hits only the selected pointer.
`timescale 1ns/1ps
`default_nettype none
module dual_data_pointer_select
  import active_data_pointer_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Special-function register access
  input wire sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  // Core commands and flag events
  input wire core_req_t i_core,
  input wire logic i_wakeup_set,
  // Memory side
  output mem_req_t o_mem,
  output logic o_pointer_select
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic [7:0] aux_ff;
  logic [7:0] nxt_aux;
  logic [PTR_COUNT-1:0][PTR_WIDTH-1:0] ptrs;
  logic [PTR_WIDTH-1:0] sel_ptr;
  logic sel;
  logic aux_wr;
  logic lo_wr;
  logic hi_wr;
  logic [PTR_WIDTH-1:0] acc_ext;

  assign sel = aux_ff[AUX_SEL_BIT]; // see [RULE2]
  assign sel_ptr = ptrs[sel]; // see [RULE6]
  assign aux_wr = i_sfr.wr && (i_sfr.addr == SFR_AUX_ADDR); // see [RULE3]
  assign lo_wr = i_sfr.wr && (i_sfr.addr == SFR_PTR_LO_ADDR); // see [RULE13]
  assign hi_wr = i_sfr.wr && (i_sfr.addr == SFR_PTR_HI_ADDR); // see [RULE13]
  assign acc_ext = {8'h00, i_core.accumulator};

  // ****************************************************************
  // Auxiliary control register
  // ****************************************************************
  // A core increment and a bus write in the same cycle: the increment
  // wins, because it is the instruction actually executing.
  always_comb
  begin
    nxt_aux = aux_ff;
    if (i_core.cmd == CMD_AUX_INC)
    begin
      // Bit 2 always holds zero, so a carry out of bits 1:0 dies there
      // and never reaches the flags above it.
      nxt_aux = (aux_ff + 8'h01) & AUX_WRITE_MASK; // see [RULE5]
    end
    else if (aux_wr)
    begin
      nxt_aux = i_sfr.wdata & AUX_WRITE_MASK; // see [RULE4]
    end
    if (i_wakeup_set)
    begin
      nxt_aux[AUX_WAKE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      aux_ff <= AUX_RESET; // see [RULE3]
    end
    else
    begin
      aux_ff <= nxt_aux;
    end
  end

  assign o_pointer_select = aux_ff[AUX_SEL_BIT];

  // ****************************************************************
  // Pointer bank
  // ****************************************************************
  data_pointer_bank #(
    .WIDTH(PTR_WIDTH),
    .COUNT(PTR_COUNT)
  ) u_bank (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_sel(sel), // see [RULE15]
    .i_inc(i_core.cmd == CMD_PTR_INC), // see [RULE7]
    .i_load(i_core.cmd == CMD_PTR_LOAD), // see [RULE8]
    .i_imm(i_core.imm),
    .i_wr_lo(lo_wr),
    .i_wr_hi(hi_wr),
    .i_byte(i_sfr.wdata),
    .o_ptr(ptrs) // see [RULE1]
  );

  // ****************************************************************
  // Register read port
  // ****************************************************************
  logic [7:0] sfr_rdata_ff;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      sfr_rdata_ff <= SFR_UNMAPPED_DATA;
    end
    else if (i_sfr.rd)
    begin
      unique case (i_sfr.addr)
        SFR_AUX_ADDR: sfr_rdata_ff <= aux_ff & AUX_WRITE_MASK; // see [RULE4]
        SFR_PTR_LO_ADDR: sfr_rdata_ff <= sel_ptr[7:0]; // see [RULE13]
        SFR_PTR_HI_ADDR: sfr_rdata_ff <= sel_ptr[15:8]; // see [RULE13]
        default: sfr_rdata_ff <= SFR_UNMAPPED_DATA;
      endcase
    end
  end

  assign o_sfr_rdata = sfr_rdata_ff;

  // ****************************************************************
  // Memory requests
  // ****************************************************************
  // Addresses use the pointer value from before any same-cycle change.
  mem_req_t mem_ff;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      mem_ff <= '0;
    end
    else
    begin
      mem_ff <= '0;
      mem_ff.wdata <= i_core.accumulator;
      unique case (i_core.cmd)
        CMD_CODE_READ:
        begin
          mem_ff.addr <= sel_ptr + acc_ext; // see [RULE9]
          mem_ff.code_rd <= 1'b1;
        end
        CMD_EXT_READ:
        begin
          mem_ff.addr <= sel_ptr; // see [RULE10]
          mem_ff.ext_rd <= 1'b1;
        end
        CMD_EXT_WRITE:
        begin
          mem_ff.addr <= sel_ptr; // see [RULE11]
          mem_ff.ext_wr <= 1'b1;
        end
        CMD_JUMP:
        begin
          mem_ff.addr <= sel_ptr + acc_ext; // see [RULE12]
          mem_ff.jump <= 1'b1;
        end
        default:
        begin
          mem_ff.addr <= sel_ptr;
        end
      endcase
    end
  end

  assign o_mem = mem_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_plain_aux_write;
    aux_wr && (i_core.cmd != CMD_AUX_INC);
  endsequence

  sequence s_aux_inc_quiet;
    (i_core.cmd == CMD_AUX_INC) && !i_wakeup_set;
  endsequence

  a_select_from_write: assert property ( // see [RULE2]
    s_plain_aux_write |=> o_pointer_select == $past(i_sfr.wdata[AUX_SEL_BIT]))
    else $error("pointer select does not follow aux write");

  a_reset_clears_aux: assert property ( // see [RULE3]
    $past(i_rst) |-> (aux_ff[AUX_WAKE_BIT] == 1'b0) && (aux_ff[AUX_ZERO_BIT] == 1'b0)
      && (o_pointer_select == 1'b0))
    else $error("aux bits not cleared by reset");

  a_aux_bit2_zero: assert property ( // see [RULE4]
    (i_sfr.rd && i_sfr.addr == SFR_AUX_ADDR) ##1 1'b1 |-> o_sfr_rdata[AUX_ZERO_BIT] == 1'b0)
    else $error("aux bit 2 read back as one");

  a_aux_inc_toggle: assert property ( // see [RULE5]
    s_aux_inc_quiet |=> (o_pointer_select != $past(o_pointer_select))
      && (aux_ff[AUX_WAKE_BIT] == $past(aux_ff[AUX_WAKE_BIT]))
      && (aux_ff[AUX_LOWPWR_BIT] == $past(aux_ff[AUX_LOWPWR_BIT])))
    else $error("aux increment disturbed flags or kept select");

  a_ptr_inc_selected: assert property ( // see [RULE7]
    (i_core.cmd == CMD_PTR_INC) |=> (ptrs[$past(sel)] == $past(sel_ptr) + PTR_STEP)
      && (ptrs[!$past(sel)] == $past(ptrs[!sel])))
    else $error("pointer increment wrong or hit unselected pointer");

  a_ptr_load_imm: assert property ( // see [RULE8]
    ((i_core.cmd == CMD_PTR_LOAD) && !aux_wr) ##1 (i_core.cmd == CMD_EXT_READ) |=>
      o_mem.ext_rd && (o_mem.addr == $past(i_core.imm, 2)))
    else $error("loaded pointer not used by following read");

  a_code_read_addr: assert property ( // see [RULE9]
    (i_core.cmd == CMD_CODE_READ) |=> o_mem.code_rd
      && (o_mem.addr == $past(sel_ptr) + {8'h00, $past(i_core.accumulator)}))
    else $error("code read address wrong");

  a_ext_read_addr: assert property ( // see [RULE10]
    (i_core.cmd == CMD_EXT_READ) |=> o_mem.ext_rd && !o_mem.ext_wr
      && (o_mem.addr == $past(ptrs[sel])))
    else $error("external read address wrong");

  a_ext_write_data: assert property ( // see [RULE11]
    (i_core.cmd == CMD_EXT_WRITE) |=> o_mem.ext_wr && (o_mem.addr == $past(sel_ptr))
      && (o_mem.wdata == $past(i_core.accumulator)))
    else $error("external write address or data wrong");

  a_jump_target: assert property ( // see [RULE12]
    (i_core.cmd == CMD_JUMP) |=> o_mem.jump && !o_mem.code_rd
      && (o_mem.addr == $past(sel_ptr) + {8'h00, $past(i_core.accumulator)}))
    else $error("jump target wrong");

  a_byte_write_sel: assert property ( // see [RULE15]
    lo_wr && (i_core.cmd == CMD_NOP) |=> (ptrs[$past(sel)][7:0] == $past(i_sfr.wdata))
      && (ptrs[$past(sel)][15:8] == $past(sel_ptr[15:8]))
      && (ptrs[!$past(sel)] == $past(ptrs[!sel])))
    else $error("low byte write reached wrong pointer");

  a_high_byte_read: assert property ( // see [RULE13]
    i_sfr.rd && (i_sfr.addr == SFR_PTR_HI_ADDR) |=> o_sfr_rdata == $past(sel_ptr[15:8]))
    else $error("high byte read wrong");

  // ****************************************************************
  // Pointer bank, read port, aux register and memory request checks
  // ****************************************************************
  // Byte writes are checked only without a competing core command, since the core wins.
  sequence s_plain_hi_write;
    hi_wr && (i_core.cmd == CMD_NOP);
  endsequence

  a_hi_byte_write: assert property ( // see [RULE13]
    s_plain_hi_write |=> (ptrs[$past(sel)][15:8] == $past(i_sfr.wdata))
      && (ptrs[$past(sel)][7:0] == $past(sel_ptr[7:0]))
      && (ptrs[!$past(sel)] == $past(ptrs[!sel])))
    else $error("high byte write reached wrong pointer");

  a_low_byte_read: assert property ( // see [RULE13]
    i_sfr.rd && (i_sfr.addr == SFR_PTR_LO_ADDR) |=> o_sfr_rdata == $past(sel_ptr[7:0]))
    else $error("low byte read wrong");

  a_rdata_holds: assert property ( // see [RULE13]
    !i_sfr.rd |=> $stable(o_sfr_rdata))
    else $error("read data changed without a read");

  a_load_selected: assert property ( // see [RULE8]
    (i_core.cmd == CMD_PTR_LOAD) |=> (ptrs[$past(sel)] == $past(i_core.imm))
      && (ptrs[!$past(sel)] == $past(ptrs[!sel])))
    else $error("pointer load wrong or hit unselected pointer");

  a_aux_write_mask: assert property ( // see [RULE4]
    s_plain_aux_write ##0 !i_wakeup_set |=> (aux_ff[AUX_ZERO_BIT] == 1'b0)
      && (aux_ff[AUX_WAKE_BIT] == $past(i_sfr.wdata[AUX_WAKE_BIT]))
      && (aux_ff[AUX_LOWPWR_BIT] == $past(i_sfr.wdata[AUX_LOWPWR_BIT])))
    else $error("aux write stored wrong flags");

  a_select_holds: assert property ( // see [RULE2]
    !aux_wr && (i_core.cmd != CMD_AUX_INC) |=> $stable(o_pointer_select))
    else $error("pointer select changed without a write or increment");

  a_strobe_single: assert property ( // see [RULE1]
    $onehot0({o_mem.code_rd, o_mem.ext_rd, o_mem.ext_wr, o_mem.jump}))
    else $error("more than one memory strobe at once");

  a_idle_no_strobe: assert property ( // see [RULE6]
    (i_core.cmd == CMD_NOP) |=> !o_mem.ext_rd && !o_mem.ext_wr
      && !o_mem.code_rd && !o_mem.jump
      && (o_mem.addr == $past(sel_ptr)))
    else $error("idle cycle raised a memory strobe");

endmodule : dual_data_pointer_select
`default_nettype wire

// *** dv/mem_side_model.sv ***
// Memory-side model: keeps the last strobed request of the pointer block.
// Assumes one-cycle strobes on the core clock; i_clr empties the record.
`timescale 1ns/1ps
`default_nettype none
module mem_side_model
  import active_data_pointer_pkg::*;
(
  // Clock and control
  input wire logic i_ref_clk,
  input wire logic i_clr,
  // Observed request
  input wire mem_req_t i_mem,
  output mem_req_t o_last
);
  // Sticky capture, so a one-cycle strobe is never missed by the bench.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_clr)
    begin
      o_last <= '0;
    end
    else if (i_mem.code_rd | i_mem.ext_rd | i_mem.ext_wr | i_mem.jump)
    begin
      o_last <= i_mem;
    end
  end
endmodule : mem_side_model
`default_nettype wire

// *** dv/dual_data_pointer_select_tb.sv ***
// Self-checking bench for the dual data pointer block.
// Assumes inputs change on the falling edge and the design answers one cycle late.
`timescale 1ns/1ps
`default_nettype none
module dual_data_pointer_select_tb
  import active_data_pointer_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  sfr_req_t i_sfr = '0;
  core_req_t i_core = '0;
  logic i_wakeup_set = 1'b0;
  logic clr = 1'b0;
  logic [7:0] o_sfr_rdata;
  logic [7:0] saved;
  mem_req_t o_mem;
  mem_req_t last;
  logic o_pointer_select;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  dual_data_pointer_select i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sfr(i_sfr),
    .o_sfr_rdata(o_sfr_rdata), .i_core(i_core), .i_wakeup_set(i_wakeup_set),
    .o_mem(o_mem), .o_pointer_select(o_pointer_select));
  mem_side_model i_mem (.i_ref_clk(i_ref_clk), .i_clr(clr), .i_mem(o_mem), .o_last(last));

  initial forever #50 i_ref_clk = ~i_ref_clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic results();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Each bus task ends one idle cycle after lowering its strobe.
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge i_ref_clk);
    i_sfr.wr = 1'b0;
    @(negedge i_ref_clk);
  endtask : sfr_wr

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    i_sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge i_ref_clk);
    i_sfr.rd = 1'b0;
    @(negedge i_ref_clk);
    chk({8'h00, o_sfr_rdata}, {8'h00, exp});
  endtask : sfr_rd

  task automatic core(input cmd_t c, input logic [15:0] imm, input logic [7:0] acc);
    i_core = '{cmd: c, imm: imm, accumulator: acc};
    clr = 1'b1;
    @(negedge i_ref_clk);
    i_core.cmd = CMD_NOP;
    clr = 1'b0;
    @(negedge i_ref_clk);
  endtask : core

  task automatic mem_chk(input logic [3:0] kind, input logic [15:0] a);
    chk({12'h000, last.code_rd, last.ext_rd, last.ext_wr, last.jump}, {12'h000, kind});
    chk(last.addr, a);
  endtask : mem_chk

  // ****************************************************************
  // Timeout and main sequence
  // ****************************************************************
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      $display("ERROR at %0t: timeout", $time);
      results();
    end
  end

  initial
  begin
    repeat (8) @(negedge i_ref_clk);
    i_rst = 1'b0;
    chk({15'h0, o_pointer_select}, 16'h0000);
    sfr_rd(SFR_AUX_ADDR, 8'h00);
    sfr_rd(SFR_PTR_LO_ADDR, 8'h00);
    sfr_wr(SFR_AUX_ADDR, 8'hFF);
    sfr_rd(SFR_AUX_ADDR, 8'hFB);
    chk({15'h0, o_pointer_select}, 16'h0001);
    core(CMD_AUX_INC, 16'h0000, 8'h00);
    sfr_rd(SFR_AUX_ADDR, 8'hF8);
    core(CMD_AUX_INC, 16'h0000, 8'h00);
    sfr_rd(SFR_AUX_ADDR, 8'hF9);
    core(CMD_PTR_LOAD, 16'hABCD, 8'h00);
    sfr_wr(SFR_AUX_ADDR, 8'h00);
    core(CMD_PTR_LOAD, 16'h1234, 8'h00);
    core(CMD_EXT_READ, 16'h0000, 8'h00);
    mem_chk(4'b0100, 16'h1234);
    sfr_rd(SFR_AUX_ADDR, 8'h00);
    saved = o_sfr_rdata;
    core(CMD_AUX_INC, 16'h0000, 8'h00);
    core(CMD_EXT_WRITE, 16'h0000, 8'h5A);
    mem_chk(4'b0010, 16'hABCD);
    chk({8'h00, last.wdata}, 16'h005A);
    sfr_wr(SFR_PTR_LO_ADDR, 8'hEF);
    core(CMD_EXT_READ, 16'h0000, 8'h00);
    mem_chk(4'b0100, 16'hABEF);
    sfr_rd(SFR_PTR_HI_ADDR, 8'hAB);
    sfr_wr(SFR_PTR_HI_ADDR, 8'hC3);
    sfr_rd(SFR_PTR_HI_ADDR, 8'hC3);
    sfr_wr(SFR_AUX_ADDR, saved);
    sfr_rd(SFR_PTR_LO_ADDR, 8'h34);
    // A load followed at once by a read: the read must use the new value.
    i_core = '{cmd: CMD_PTR_LOAD, imm: 16'h2468, accumulator: 8'h00};
    clr = 1'b1;
    @(negedge i_ref_clk);
    i_core.cmd = CMD_EXT_READ;
    clr = 1'b0;
    @(negedge i_ref_clk);
    i_core.cmd = CMD_NOP;
    @(negedge i_ref_clk);
    mem_chk(4'b0100, 16'h2468);
    core(CMD_PTR_LOAD, 16'h00FF, 8'h00);
    core(CMD_PTR_INC, 16'h0000, 8'h00);
    sfr_rd(SFR_PTR_HI_ADDR, 8'h01);
    sfr_rd(SFR_PTR_LO_ADDR, 8'h00);
    core(CMD_CODE_READ, 16'h0000, 8'h80);
    mem_chk(4'b1000, 16'h0180);
    core(CMD_JUMP, 16'h0000, 8'hFF);
    mem_chk(4'b0001, 16'h01FF);
    core(CMD_PTR_LOAD, 16'hFFFF, 8'h00);
    core(CMD_PTR_INC, 16'h0000, 8'h00);
    sfr_rd(SFR_PTR_HI_ADDR, 8'h00);
    sfr_wr(8'h90, 8'hFF);
    sfr_rd(8'h90, SFR_UNMAPPED_DATA);
    // The core increment beats a bus write to the same register.
    i_sfr = '{addr: SFR_AUX_ADDR, wr: 1'b1, rd: 1'b0, wdata: 8'h00};
    i_core.cmd = CMD_AUX_INC;
    @(negedge i_ref_clk);
    i_sfr.wr = 1'b0;
    i_core.cmd = CMD_NOP;
    @(negedge i_ref_clk);
    sfr_rd(SFR_AUX_ADDR, 8'h01);
    i_wakeup_set = 1'b1;
    @(negedge i_ref_clk);
    i_wakeup_set = 1'b0;
    @(negedge i_ref_clk);
    sfr_rd(SFR_AUX_ADDR, 8'h09);
    core(CMD_PTR_LOAD, 16'h5A5A, 8'h00);
    i_rst = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_rst = 1'b0;
    chk({15'h0, o_pointer_select}, 16'h0000);
    sfr_rd(SFR_AUX_ADDR, 8'h00);
    sfr_rd(SFR_PTR_HI_ADDR, 8'h00);
    core(CMD_AUX_INC, 16'h0000, 8'h00);
    sfr_rd(SFR_PTR_HI_ADDR, 8'h00);
    results();
  end
endmodule : dual_data_pointer_select_tb
`default_nettype wire
